// ==== design/command_group_framer.sv ====
// Notes on behaviour
// RL1 - Count byte equals whole group length
// RL2 - Counts outside 4..155 give communications error
// RL3 - CRC-16 poly 8005, zero seed, checked
// RL4 - CRC low byte sent first, high last
// RL5 - Opcode, first parameter, two-byte second, data
// RL6 - Length mismatch left to the executing command
// RL7 - Busy after last byte; nothing readable
// RL8 - While busy, incoming line activity ignored
// RL9 - One output buffer, always full groups
// RL10 - No reads until whole input group arrives
// RL11 - Status group holds one code, 00 success
// RL12 - Miscompare reports 01
// RL13 - Illegal length or fields report 03
// RL14 - Curve computation fault reports 05
// RL15 - Self-test failure reports 07, sticks
// RL16 - Random health failure reports 08, sticks
// RL17 - Wrong device state reports 0F
// RL18 - After wake, output holds 11
// RL19 - Guard timer nearly expired reports EE
// RL20 - Communications failure reports FF, no execution
// RL21 - CRC error outranks every other error
// RL22 - CRC fed count first, bytes LSB first
`default_nettype none
module command_group_framer
    import framer_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       link_clk,
    input  wire logic       link_rx_valid,
    input  wire logic [7:0] link_rx_byte,
    output var  logic       link_rx_ready,
    input  wire logic       link_rd_req,
    output var  logic       link_tx_valid,
    output var  logic [7:0] link_tx_byte,
    output var  logic       link_tx_none,
    input  wire logic       wake,
    input  wire logic       fail_clear,
    input  wire logic       guard_low,
    output var  logic       cmd_start,
    output var  logic [7:0] cmd_opcode,
    output var  logic [7:0] cmd_first_parameter,
    output var  logic [15:0] cmd_second_parameter,
    output var  logic [7:0] cmd_data_len,
    input  wire logic [7:0] cmd_data_index,
    output var  logic [7:0] cmd_data_byte,
    input  wire logic       exec_wr_valid,
    input  wire logic [7:0] exec_wr_index,
    input  wire logic [7:0] exec_wr_byte,
    input  wire logic       exec_done,
    input  wire logic [7:0] exec_status,
    input  wire logic [7:0] exec_res_len,
    output var  logic       rng_fault,
    output var  logic       busy
);
    // Link-domain state
    logic       rx_tog_lq;
    logic [7:0] rx_hold_lq;
    logic       rd_tog_lq;
    logic       rd_pend_lq;
    logic       rx_ack_s;
    logic       rd_ack_s;
    logic       busy_s;
    // Core-domain state
    state_type  state_q;
    logic       rx_tog_s;
    logic       rd_tog_s;
    logic       rx_ack_q;
    logic       rd_ack_q;
    logic [7:0] tx_byte_q;
    logic       tx_none_q;
    logic [7:0] count_q;
    logic [7:0] rx_cnt_q;
    logic [7:0] crc_lo_q;
    logic [7:0] out_len_q;
    logic [7:0] rd_idx_q;
    logic       fail_q;
    logic       rng_fail_q;
    logic [7:0] in_mem  [PKT_BYTES_MAX];
    logic [7:0] out_mem [OUT_BYTES_MAX];
    logic [15:0] crc_val;
    logic       crc_start;
    logic       crc_en;
    logic [7:0] crc_byte;
    logic       rx_evt;
    logic       rd_evt;
    logic       rd_take;
    logic       last_byte;
    logic       crc_bad;
    logic       status_load;
    logic [7:0] status_code;
    logic       go_exec;
    logic [7:0] rd_byte;

    function automatic logic count_ok(input logic [7:0] c);
        return (c >= COUNT_MIN) && (c <= COUNT_MAX);
    endfunction

    // Toggles cross each way through two flops
    sync2 #(.WIDTH(2)) u_core_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({rx_tog_lq, rd_tog_lq}),
        .sync_out ({rx_tog_s, rd_tog_s})
    );
    sync2 #(.WIDTH(3)) u_link_sync (
        .clock    (link_clk),
        .rst_n    (rst_n),
        .async_in ({rx_ack_q, rd_ack_q, busy}),
        .sync_out ({rx_ack_s, rd_ack_s, busy_s})
    );

    // Link side of the byte intake; the held byte stays put until its ack returns
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_tog_lq     <= 1'b0;
            rx_hold_lq    <= 8'h00;
            link_rx_ready <= 1'b0;
        end else begin
            if (link_rx_valid && link_rx_ready) begin
                rx_tog_lq  <= ~rx_tog_lq;
                rx_hold_lq <= link_rx_byte;
            end
            link_rx_ready <= !(link_rx_valid && link_rx_ready) && (rx_ack_s == rx_tog_lq) && !busy_s; // RL8
        end
    end

    // Link side of reads; one request outstanding, extra requests dropped
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_tog_lq     <= 1'b0;
            rd_pend_lq    <= 1'b0;
            link_tx_valid <= 1'b0;
            link_tx_byte  <= 8'h00;
            link_tx_none  <= 1'b0;
        end else begin
            link_tx_valid <= 1'b0;
            if (!rd_pend_lq && link_rd_req) begin
                rd_tog_lq  <= ~rd_tog_lq;
                rd_pend_lq <= 1'b1;
            end else if (rd_pend_lq && (rd_ack_s == rd_tog_lq)) begin
                rd_pend_lq    <= 1'b0;
                link_tx_valid <= 1'b1;
                link_tx_byte  <= tx_byte_q;
                link_tx_none  <= tx_none_q;
            end
        end
    end

    assign rx_evt    = rx_tog_s != rx_ack_q;
    assign rd_evt    = rd_tog_s != rd_ack_q;
    // In idle, an arriving byte beats a read in the same cycle; the read waits a cycle
    assign rd_take   = rd_evt && !(rx_evt && (state_q == st_idle));
    assign last_byte = (state_q == st_recv) && (rx_cnt_q == count_q - 8'h01);
    assign crc_bad   = {rx_hold_lq, crc_lo_q} != crc_val; // RL3 RL4

    // Ending a group: CRC checked before anything else, then parse, then device state
    always_comb begin
        status_load = 1'b0;
        status_code = ST_SUCCESS;
        go_exec     = 1'b0;
        unique case (state_q)
            st_idle: begin
                if (rx_evt && !count_ok(rx_hold_lq)) begin
                    status_load = 1'b1; // RL2
                    status_code = ST_COMM;
                end else if (wake && !rx_evt) begin
                    status_load = 1'b1; // RL18
                    status_code = ST_WAKE;
                end
            end
            st_recv: begin
                if (rx_evt && last_byte) begin
                    status_load = 1'b1;
                    if (crc_bad) begin
                        status_code = ST_COMM; // RL20 RL21
                    end else if (count_q < PARSE_MIN) begin
                        status_code = ST_PARSE; // RL13
                    end else if (fail_q) begin
                        status_code = ST_SELF_TEST; // RL15
                    end else if (guard_low) begin
                        status_code = ST_GUARD; // RL19
                    end else begin
                        status_load = 1'b0;
                        go_exec     = 1'b1; // RL7
                    end
                end
            end
            st_busy: begin
                if (exec_done && (exec_res_len == 8'h00)) begin
                    status_load = 1'b1; // RL11 RL12 RL14 RL16 RL17
                    status_code = exec_status;
                end
            end
            default: begin
                status_load = 1'b0;
            end
        endcase
    end

    // Sequencing of receive, execute and idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= st_idle;
            busy     <= 1'b0;
            rx_ack_q <= 1'b0;
            count_q  <= 8'h00;
            rx_cnt_q <= 8'h00;
            crc_lo_q <= 8'h00;
        end else begin
            if (rx_evt) begin
                rx_ack_q <= rx_tog_s; // Bytes arriving while busy are acked and dropped
            end
            unique case (state_q)
                st_idle: begin
                    if (rx_evt && count_ok(rx_hold_lq)) begin
                        count_q  <= rx_hold_lq; // RL1
                        rx_cnt_q <= 8'h01;
                        state_q  <= st_recv;
                    end
                end
                st_recv: begin
                    if (rx_evt) begin
                        rx_cnt_q <= rx_cnt_q + 8'h01;
                        if (rx_cnt_q == count_q - CRC_BYTES) begin
                            crc_lo_q <= rx_hold_lq; // RL4
                        end
                        if (last_byte) begin
                            state_q <= go_exec ? st_busy : st_idle;
                            busy    <= go_exec; // RL7
                        end
                    end
                end
                st_busy: begin
                    if (exec_done) begin
                        state_q <= st_idle;
                        busy    <= 1'b0;
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // Packet bytes kept for the executor; trailer bytes are not stored
    always_ff @(posedge clock) begin
        if (state_q == st_recv && rx_evt && rx_cnt_q < count_q - CRC_BYTES) begin
            in_mem[rx_cnt_q - 8'h01] <= rx_hold_lq; // RL5
        end
    end

    // Command hand-off; the executor decides what a count mismatch means
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_start            <= 1'b0;
            cmd_opcode           <= 8'h00;
            cmd_first_parameter  <= 8'h00;
            cmd_second_parameter <= 16'h0000;
            cmd_data_len         <= 8'h00;
            cmd_data_byte        <= 8'h00;
        end else begin
            cmd_start <= go_exec;
            if (go_exec) begin
                cmd_opcode           <= in_mem[0]; // RL5
                cmd_first_parameter  <= in_mem[1];
                cmd_second_parameter <= {in_mem[3], in_mem[2]};
                cmd_data_len         <= count_q - PARSE_MIN; // RL6
            end
            cmd_data_byte <= in_mem[HDR_BYTES + cmd_data_index];
        end
    end

    // Sticky failure modes, cleared only on request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fail_q     <= 1'b0;
            rng_fail_q <= 1'b0;
            rng_fault  <= 1'b0;
        end else begin
            if (state_q == st_busy && exec_done && exec_status == ST_SELF_TEST) begin
                fail_q <= 1'b1; // RL15
            end else if (fail_clear) begin
                fail_q <= 1'b0;
            end
            if (state_q == st_busy && exec_done && exec_status == ST_HEALTH) begin
                rng_fail_q <= 1'b1; // RL16
            end else if (fail_clear) begin
                rng_fail_q <= 1'b0;
            end
            rng_fault <= rng_fail_q;
        end
    end

    // Single output buffer shared by status codes and results
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_len_q <= 8'h01;
        end else if (status_load) begin
            out_len_q <= 8'h01; // RL9 RL11
        end else if (state_q == st_busy && exec_done) begin
            out_len_q <= exec_res_len;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_mem[0] <= ST_WAKE; // RL18
        end else if (status_load) begin
            out_mem[0] <= status_code; // RL9
        end else if (state_q == st_busy && exec_wr_valid) begin
            out_mem[exec_wr_index] <= exec_wr_byte;
        end
    end

    // Byte for the current read position: count, packet, CRC low, CRC high
    always_comb begin
        if (rd_idx_q == 8'h00) begin
            rd_byte = out_len_q + GROUP_EXTRA; // RL1
        end else if (rd_idx_q <= out_len_q) begin
            rd_byte = out_mem[rd_idx_q - 8'h01];
        end else if (rd_idx_q == out_len_q + 8'h01) begin
            rd_byte = crc_val[7:0]; // RL4
        end else begin
            rd_byte = crc_val[15:8];
        end
    end

    // Read answers; a group may be read again once it has wrapped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_q  <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_none_q <= 1'b0;
            rd_idx_q  <= 8'h00;
        end else begin
            if (rd_take) begin
                rd_ack_q  <= rd_tog_s;
                tx_none_q <= state_q != st_idle; // RL7 RL10
                tx_byte_q <= rd_byte;
            end
            if (status_load || (state_q == st_busy && exec_done)) begin
                rd_idx_q <= 8'h00;
            end else if (rd_take && state_q == st_idle) begin
                rd_idx_q <= (rd_idx_q == out_len_q + CRC_BYTES) ? 8'h00 : rd_idx_q + 8'h01;
            end
        end
    end

    // One CRC engine serves both directions; traffic is half duplex
    always_comb begin
        crc_start = 1'b0;
        crc_en    = 1'b0;
        crc_byte  = rx_hold_lq;
        if (state_q == st_idle && rx_evt) begin
            crc_start = 1'b1; // RL22
            crc_en    = count_ok(rx_hold_lq);
        end else if (state_q == st_recv && rx_evt && rx_cnt_q < count_q - CRC_BYTES) begin
            crc_en = 1'b1; // RL3
        end else if (state_q == st_idle && rd_take && rd_idx_q <= out_len_q) begin
            crc_start = rd_idx_q == 8'h00;
            crc_en    = 1'b1;
            crc_byte  = rd_byte;
        end
    end
    crc16_step u_crc (
        .clock (clock),
        .rst_n (rst_n),
        .start (crc_start),
        .en    (crc_en),
        .data  (crc_byte),
        .crc   (crc_val)
    );

    sequence s_read_taken;
        rd_take;
    endsequence
    sequence s_answer_none;
        tx_none_q && (rd_ack_q == $past(rd_tog_s));
    endsequence

    property p_count_byte;
        @(posedge clock) disable iff (!rst_n)
        (s_read_taken and (state_q == st_idle && rd_idx_q == 8'h00)) |=> tx_byte_q == $past(out_len_q) + GROUP_EXTRA;
    endproperty
    a_count_byte: assert property (p_count_byte) else $error("count byte wrong"); // RL1

    property p_range;
        @(posedge clock) disable iff (!rst_n)
        (state_q == st_idle && rx_evt && !count_ok(rx_hold_lq)) |=> state_q == st_idle && out_mem[0] == ST_COMM;
    endproperty
    a_range: assert property (p_range) else $error("bad count not answered with FF"); // RL2

    property p_crc_low_first;
        @(posedge clock) disable iff (!rst_n)
        (state_q == st_idle && rd_take && rd_idx_q == out_len_q + 8'h01) |=> tx_byte_q == $past(crc_val[7:0]);
    endproperty
    a_crc_low_first: assert property (p_crc_low_first) else $error("CRC low byte not sent first"); // RL4

    property p_busy_read;
        @(posedge clock) disable iff (!rst_n)
        (s_read_taken and busy) |=> s_answer_none;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("read answered while busy"); // RL7

    property p_busy_ignores;
        @(posedge link_clk) disable iff (!rst_n)
        busy_s |=> !link_rx_ready;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("intake open while busy"); // RL8

    property p_partial_read;
        @(posedge clock) disable iff (!rst_n)
        (s_read_taken and (state_q == st_recv)) |=> s_answer_none;
    endproperty
    a_partial_read: assert property (p_partial_read) else $error("read answered mid group"); // RL10

    property p_wake;
        @(posedge clock) disable iff (!rst_n)
        (state_q == st_idle && wake && !rx_evt) |=> out_mem[0] == ST_WAKE && out_len_q == 8'h01;
    endproperty
    a_wake: assert property (p_wake) else $error("wake status missing"); // RL18

    property p_crc_first;
        @(posedge clock) disable iff (!rst_n)
        (rx_evt && last_byte && crc_bad) |=> !cmd_start && out_mem[0] == ST_COMM && !busy;
    endproperty
    a_crc_first: assert property (p_crc_first) else $error("CRC error not reported first"); // RL20 RL21

    property p_fail_sticky;
        @(posedge clock) disable iff (!rst_n)
        fail_q |=> !cmd_start;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("command run in failure mode"); // RL15

    property p_start_busy;
        @(posedge clock) disable iff (!rst_n)
        cmd_start |-> busy ##1 (busy || exec_done || $past(exec_done));
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start without busy"); // RL7
endmodule
`default_nettype wire

// ==== common/framer_pkg.sv ====
`default_nettype none
package framer_pkg;
    // Group framing
    localparam logic [7:0] COUNT_MIN     = 8'h04;
    localparam logic [7:0] COUNT_MAX     = 8'h9b;
    localparam logic [7:0] GROUP_EXTRA   = 8'h03;
    localparam logic [7:0] CRC_BYTES     = 8'h02;
    localparam logic [7:0] HDR_BYTES     = 8'h04;
    localparam logic [7:0] PARSE_MIN     = 8'h07;
    localparam int         PKT_BYTES_MAX = 152;
    localparam int         OUT_BYTES_MAX = 152;
    localparam logic [15:0] CRC_POLY     = 16'h8005;
    localparam logic [15:0] CRC_SEED     = 16'h0000;

    // Status codes of a four-byte group
    localparam logic [7:0] ST_SUCCESS    = 8'h00;
    localparam logic [7:0] ST_MISCOMPARE = 8'h01;
    localparam logic [7:0] ST_PARSE      = 8'h03;
    localparam logic [7:0] ST_ECC_FAULT  = 8'h05;
    localparam logic [7:0] ST_SELF_TEST  = 8'h07;
    localparam logic [7:0] ST_HEALTH     = 8'h08;
    localparam logic [7:0] ST_EXEC       = 8'h0f;
    localparam logic [7:0] ST_WAKE       = 8'h11;
    localparam logic [7:0] ST_GUARD      = 8'hee;
    localparam logic [7:0] ST_COMM       = 8'hff;

    // Core sequencing
    typedef enum logic [1:0] {st_idle, st_recv, st_busy} state_type;
endpackage
`default_nettype wire

// ==== design/sync2.sv ====
`default_nettype none
// Two-stage synchroniser; the first stage feeds only the second
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Metastability filter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== design/crc16_step.sv ====
`default_nettype none
// Running CRC-16, one byte per enabled clock, bit 0 of each byte first
module crc16_step
    import framer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output var  logic [15:0] crc
);
    // Eight serial shifts folded into one step
    function automatic logic [15:0] step(input logic [15:0] seed, input logic [7:0] din);
        logic [15:0] c;
        c = seed;
        for (int i = 0; i < 8; i++) begin
            if (din[i] ^ c[15]) begin
                c = {c[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Start reseeds from zero so a fresh group never inherits old state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            crc <= CRC_SEED;
        end else if (en) begin
            crc <= step(start ? CRC_SEED : crc, data);
        end
    end
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`default_nettype none
// Host end of the byte link: offers group bytes and fetches answer bytes
module host_model (
    input  wire logic       link_clk,
    input  wire logic       link_rx_ready,
    input  wire logic       link_tx_valid,
    input  wire logic [7:0] link_tx_byte,
    input  wire logic       link_tx_none,
    output var  logic       link_rx_valid,
    output var  logic [7:0] link_rx_byte,
    output var  logic       link_rd_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels before the first request
    initial begin
        link_rx_valid = 1'b0;
        link_rx_byte  = 8'h5a;
        link_rd_req   = 1'b0;
    end
    // Byte and valid stay put until the intake takes them
    task automatic put(input logic [7:0] b);
        @(posedge link_clk) #1 link_rx_valid = 1'b1;
        link_rx_byte  = b;
        while (link_rx_ready !== 1'b1) @(posedge link_clk) #1;
        @(posedge link_clk) #1 link_rx_valid = 1'b0;
        link_rx_byte  = ~b; // Stale data must never look valid
    endtask
    // One outstanding read; answer taken at the edge it is flagged
    task automatic get(output logic [7:0] b, output logic none);
        @(posedge link_clk) #1 link_rd_req = 1'b1;
        @(posedge link_clk) #1 link_rd_req = 1'b0;
        do @(posedge link_clk) #1; while (link_tx_valid !== 1'b1);
        b    = link_tx_byte;
        none = link_tx_none;
    endtask
endmodule
`default_nettype wire

// ==== tb/command_group_framer_tb_top.sv ====
`default_nettype none
module command_group_framer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import framer_pkg::*;
    logic        clock, rst_n, link_clk, link_rx_valid, link_rx_ready, link_rd_req;
    logic        link_tx_valid, link_tx_none, wake, fail_clear, guard_low, cmd_start;
    logic        exec_wr_valid, exec_done, rng_fault, busy;
    logic [7:0]  link_rx_byte, link_tx_byte, cmd_opcode, cmd_first_parameter, cmd_data_len;
    logic [7:0]  cmd_data_index, cmd_data_byte, exec_wr_index, exec_wr_byte, exec_status, exec_res_len;
    logic [15:0] cmd_second_parameter;
    int          n_mismatch, compares, n_start, cycles;

    // Core clock and an unrelated link clock
    initial clock = 1'b0;
    always #20 clock = ~clock;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end

    command_group_framer dut (.clock, .rst_n, .link_clk, .link_rx_valid, .link_rx_byte, .link_rx_ready,
        .link_rd_req, .link_tx_valid, .link_tx_byte, .link_tx_none, .wake, .fail_clear, .guard_low,
        .cmd_start, .cmd_opcode, .cmd_first_parameter, .cmd_second_parameter, .cmd_data_len,
        .cmd_data_index, .cmd_data_byte, .exec_wr_valid, .exec_wr_index, .exec_wr_byte, .exec_done,
        .exec_status, .exec_res_len, .rng_fault, .busy);
    host_model host (.link_clk, .link_rx_ready, .link_tx_valid, .link_tx_byte, .link_tx_none,
        .link_rx_valid, .link_rx_byte, .link_rd_req);

    // Count handed-over commands mid-cycle, away from the launching edge, and cut a hang short
    always @(negedge clock) begin
        cycles++;
        if (cmd_start === 1'b1) n_start++;
        if (cycles == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Checksum fed bit 0 first, register cleared before the count byte
    function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (q[i])
            for (int k = 0; k < 8; k++)
                c = (q[i][k] ^ c[15]) ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
        return c;
    endfunction

    // Bad flips bit 0 of the checksum; peek reads once after the count byte
    task automatic send(input logic [7:0] q[$], input logic bad, input logic peek);
        logic [15:0] c;
        logic [7:0]  b;
        logic        n;
        c = crc_of(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            host.put(q[i]);
            if (peek && i == 0) begin
                host.get(b, n);
                check("none while receiving", {15'h0, n}, 16'h0001);
            end
        end
    endtask

    task automatic read_group(input logic [7:0] pkt[$]);
        logic [7:0]  g[$];
        logic [15:0] c;
        logic [7:0]  b;
        logic        n;
        g = pkt;
        g.push_front(8'(pkt.size() + 3));
        c = crc_of(g);
        g.push_back(c[7:0]);
        g.push_back(c[15:8]);
        foreach (g[i]) begin
            host.get(b, n);
            check("answer none", {15'h0, n}, 16'h0000);
            check("answer byte", {8'h00, b}, {8'h00, g[i]});
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic peek);
        send('{8'h09, op, 8'ha5, 8'h34, 8'h12, 8'hc3, 8'h3c}, 1'b0, peek);
    endtask

    task automatic expect_start();
        for (int k = 0; k < 300; k++) begin
            @(posedge clock) #1;
            if (cmd_start === 1'b1) break;
        end
        check("command start", {15'h0, cmd_start}, 16'h0001);
        check("busy", {15'h0, busy}, 16'h0001);
    endtask

    // Executor writes two result bytes unless the length is zero, then ends with a status
    task automatic finish_exec(input logic [7:0] st, input logic [7:0] len);
        @(posedge clock) #1 exec_wr_valid = (len != 8'h00);
        exec_wr_index = 8'h00;
        exec_wr_byte  = 8'h6e;
        @(posedge clock) #1 exec_wr_index = 8'h01;
        exec_wr_byte  = 8'h91;
        @(posedge clock) #1 exec_wr_valid = 1'b0;
        exec_done     = 1'b1;
        exec_status   = st;
        exec_res_len  = len;
        @(posedge clock) #1 exec_done = 1'b0;
    endtask

    task automatic s_command();
        logic [7:0] b;
        logic       n;
        cmd(8'h47, 1'b1);
        expect_start();
        repeat (2) @(posedge clock);
        check("opcode", {8'h00, cmd_opcode}, 16'h0047);
        check("first parameter", {8'h00, cmd_first_parameter}, 16'h00a5);
        check("second parameter", cmd_second_parameter, 16'h1234);
        check("data length", {8'h00, cmd_data_len}, 16'h0002);
        check("data byte", {8'h00, cmd_data_byte}, 16'h003c);
        host.get(b, n);
        check("none while busy", {15'h0, n}, 16'h0001);
        check("intake shut", {15'h0, link_rx_ready}, 16'h0000);
        finish_exec(ST_SUCCESS, 8'h02);
        read_group('{8'h6e, 8'h91});
    endtask

    task automatic s_codes();
        logic [7:0] codes[5] = '{ST_SUCCESS, ST_MISCOMPARE, ST_ECC_FAULT, ST_EXEC, ST_HEALTH};
        int         s0;
        foreach (codes[i]) begin
            cmd(8'h10 + 8'(i), 1'b0);
            expect_start();
            finish_exec(codes[i], 8'h00);
            read_group('{codes[i]});
        end
        check("rng fault", {15'h0, rng_fault}, 16'h0001);
        cmd(8'h20, 1'b0);
        expect_start();
        finish_exec(ST_SELF_TEST, 8'h00);
        read_group('{ST_SELF_TEST});
        s0 = n_start;
        cmd(8'h21, 1'b0);
        read_group('{ST_SELF_TEST});
        check("no start in failure", 16'(n_start - s0), 16'h0000);
        @(posedge clock) #1 fail_clear = 1'b1;
        @(posedge clock) #1 fail_clear = 1'b0;
        repeat (3) @(posedge clock);
        check("rng fault cleared", {15'h0, rng_fault}, 16'h0000);
    endtask

    task automatic s_errors();
        int s0;
        s0 = n_start;
        @(posedge clock) #1 guard_low = 1'b1;
        send('{8'h09, 8'h30, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 1'b1, 1'b0);
        read_group('{ST_COMM});
        cmd(8'h31, 1'b0);
        read_group('{ST_GUARD});
        guard_low = 1'b0;
        host.put(8'h03);
        read_group('{ST_COMM});
        host.put(8'h9c);
        read_group('{ST_COMM});
        send('{8'h04, 8'h32}, 1'b0, 1'b0);
        read_group('{ST_PARSE});
        check("no start on refusals", 16'(n_start - s0), 16'h0000);
        @(posedge clock) #1 wake = 1'b1;
        @(posedge clock) #1 wake = 1'b0;
        read_group('{ST_WAKE});
    endtask

    // Reset for three cycles, then the scenarios in turn
    initial begin
        {rst_n, wake, fail_clear, guard_low, exec_wr_valid, exec_done} = '0;
        {exec_wr_index, exec_wr_byte, exec_status, exec_res_len} = '0;
        cmd_data_index = 8'h01;
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge link_clk);
        read_group('{ST_WAKE});
        read_group('{ST_WAKE});
        s_command();
        s_codes();
        s_errors();
        report_and_stop();
    end
endmodule
`default_nettype wire
